// >>> serial_port_flow_control.sv
`timescale 1ns/1ps
// Functional notes
// - The first async port resets to 1200 bit/s, 8 data, 1 stop, no parity.
// - The front panel port resets to 9600 bit/s, 8 data, 1 stop, no parity.
// - Every port takes a written baud rate and mode over its default.
// - Mode 0 takes CTS and CD as asserted inside, so receive never stops.
// - Modes 0 and 3 raise RTS before sending and drop it when done.
// - The first program RTS command in mode 0 moves the port to mode 1.
// - Mode 1 ignores the modem lines; RTS is the program's, CTS/CD read.
// - Mode 2 sends only with CTS, takes CD as asserted, RTS is manual.
// - In modes 3 and 4 a program RTS holds until the buffer drains.
// - In modes 3 and 4 the RTS turn-off delay after the last character is configurable.
// - Mode 4 receives only with CD and sends after RTS then CTS.
// - Mode 5 sends with CTS and drives RTS from receive fill watermarks.
// - Mode 6 merges modes 0 and 2 into an RTS/CTS handshake.
module serial_port_flow_control
  import serial_flow_pkg::*;
#(
  parameter int unsigned PORT_INDEX = 0
) (
  input logic ref_clk,
  input logic nrst,
  input logic cfgWrite,
  input serial_flow_pkg::port_cfg_t cfgIn,
  output serial_flow_pkg::port_cfg_t cfgOut,
  input logic [7:0] txData,
  input logic txValid,
  output logic txReady,
  output logic txBusy,
  input logic rtsCmdValid,
  input logic rtsCmdOn,
  input logic [serial_flow_pkg::DELAY_W-1:0] rtsOffDelay,
  input logic [serial_flow_pkg::FILL_W-1:0] rxFill,
  input logic [serial_flow_pkg::FILL_W-1:0] rxLowMark,
  input logic [serial_flow_pkg::FILL_W-1:0] rxHighMark,
  input logic ctsIn,
  input logic cdIn,
  input logic rxd,
  output logic txd,
  output logic rtsOut,
  output logic ctsState,
  output logic cdState,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxFrameErr
);
  import serial_flow_pkg::*;

  if (PORT_INDEX >= PORT_COUNT) begin : g_chk_port
    $error("serial_port_flow_control: PORT_INDEX out of range");
  end
  if (DATA_BITS != 8) begin : g_chk_bits
    $error("serial_port_flow_control: only 8 data bits supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [DIV_W-1:0] bitReload(
    input logic [DIV_W-1:0] d
  );
    return d - DIV_W'(1);
  endfunction

  function automatic logic usesAutoRts(input fc_mode_t m);
    return (m == FCM_NONE) || (m == FCM_AUTO_RTS) ||
           (m == FCM_FULL_AUTO) || (m == FCM_ENHANCED);
  endfunction

  function automatic logic needsCts(input fc_mode_t m);
    return (m == FCM_AUTO_CTS) || (m == FCM_FULL_AUTO) ||
           (m == FCM_DYNAMIC) || (m == FCM_ENHANCED);
  endfunction

  function automatic logic [DIV_W-1:0] resetDivisor(input int unsigned p);
    return (p == FRONT_PORT_INDEX) ? FRONT_PORT_DIV : FIRST_PORT_DIV;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    port_cfg_t cfg;
    tx_state_t txState;
    rx_state_t rxState;
    logic [DIV_W-1:0] txCnt;
    logic [DIV_W-1:0] rxCnt;
    logic [BIT_W-1:0] txBit;
    logic [BIT_W-1:0] rxBit;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic stopLeft;
    logic progRts;
    logic autoRts;
    logic dynRts;
    logic [DELAY_W-1:0] delayCnt;
    logic txd;
    logic rts;
    logic ctsS;
    logic cdS;
    logic [7:0] rxData;
    logic rxValid;
    logic rxFrameErr;
    logic txBusy;
  } port_state_t;

  localparam port_state_t RESET_STATE = '{
    cfg: '{divisor: resetDivisor(PORT_INDEX), mode: RESET_MODE,
           stopTwo: RESET_STOP_TWO},
    txState: TX_IDLE, rxState: RX_IDLE,
    txCnt: '0, rxCnt: '0, txBit: '0, rxBit: '0,
    txShift: '0, rxShift: '0, stopLeft: 1'b0,
    progRts: 1'b0, autoRts: 1'b0, dynRts: 1'b0, delayCnt: '0,
    txd: IDLE_LEVEL, rts: 1'b0, ctsS: 1'b1, cdS: 1'b1,
    rxData: '0, rxValid: 1'b0, rxFrameErr: 1'b0, txBusy: 1'b0};

  port_state_t s_r;
  port_state_t s_nxt;

  logic [7:0] bufData;
  logic bufValid;
  logic startTx;
  logic pending;
  logic ctsGate;
  logic rxAllow;
  logic txTick;
  logic rxTick;
  logic delayUsed;

  // a stalled transmitter backs the buffer up to txReady
  two_entry_buffer #(.WIDTH(8)) u_txBuf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inData(txData),
    .inValid(txValid),
    .inReady(txReady),
    .outData(bufData),
    .outValid(bufValid),
    .outReady(startTx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flow control gates

  assign pending = bufValid | (s_r.txState != TX_IDLE);
  assign ctsGate = needsCts(s_r.cfg.mode) ? ctsIn : 1'b1;
  // mode 4 is the only one that ignores the line without carrier
  assign rxAllow = (s_r.cfg.mode != FCM_FULL_AUTO) || cdIn;
  // rts is registered, so it leads the start bit by at least a cycle
  assign startTx = bufValid && (s_r.txState == TX_IDLE) && ctsGate &&
                   (!usesAutoRts(s_r.cfg.mode) || s_r.rts);
  assign txTick = (s_r.txCnt == '0);
  assign rxTick = (s_r.rxCnt == '0);
  assign delayUsed = (s_r.cfg.mode == FCM_AUTO_RTS) ||
                     (s_r.cfg.mode == FCM_FULL_AUTO);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rxValid = 1'b0;
    s_nxt.rxFrameErr = 1'b0;

    // configuration and program rts
    if (rtsCmdValid) begin
      s_nxt.progRts = rtsCmdOn;
      if (s_r.cfg.mode == FCM_NONE) begin
        s_nxt.cfg.mode = FCM_MANUAL;
      end
    end
    if (cfgWrite) begin
      s_nxt.cfg = cfgIn;
    end

    // automatic rts with trailing delay in bit times
    s_nxt.txCnt = txTick ? bitReload(s_r.cfg.divisor)
                         : s_r.txCnt - DIV_W'(1);
    if (pending) begin
      s_nxt.autoRts = 1'b1;
      s_nxt.delayCnt = '0;
    end else if (s_r.autoRts) begin
      if (!delayUsed || s_r.delayCnt >= rtsOffDelay) begin
        s_nxt.autoRts = 1'b0;
      end else if (txTick) begin
        s_nxt.delayCnt = s_r.delayCnt + DELAY_W'(1);
      end
    end

    // receive fill hysteresis
    if (rxFill < rxLowMark) begin
      s_nxt.dynRts = 1'b1;
    end else if (rxFill > rxHighMark) begin
      s_nxt.dynRts = 1'b0;
    end

    unique case (s_r.cfg.mode)
      FCM_NONE: s_nxt.rts = s_nxt.autoRts;
      FCM_MANUAL, FCM_AUTO_CTS: s_nxt.rts = s_nxt.progRts;
      // program negation waits for the buffer through autoRts
      FCM_AUTO_RTS, FCM_FULL_AUTO: begin
        s_nxt.rts = s_nxt.autoRts | s_nxt.progRts;
      end
      FCM_ENHANCED: s_nxt.rts = s_nxt.autoRts | s_nxt.progRts;
      FCM_DYNAMIC: s_nxt.rts = s_nxt.dynRts;
      default: s_nxt.rts = 1'b0;
    endcase

    // readable line states, asserted inside where the mode says so
    unique case (s_r.cfg.mode)
      FCM_NONE, FCM_AUTO_RTS: begin
        s_nxt.ctsS = 1'b1;
        s_nxt.cdS = 1'b1;
      end
      FCM_AUTO_CTS, FCM_ENHANCED: begin
        s_nxt.ctsS = ctsIn;
        s_nxt.cdS = 1'b1;
      end
      default: begin
        s_nxt.ctsS = ctsIn;
        s_nxt.cdS = cdIn;
      end
    endcase

    // transmitter
    unique case (s_r.txState)
      TX_IDLE: begin
        s_nxt.txd = IDLE_LEVEL;
        if (startTx) begin
          s_nxt.txShift = bufData;
          s_nxt.txState = TX_START;
          s_nxt.txd = START_LEVEL;
          s_nxt.txCnt = bitReload(s_r.cfg.divisor);
        end
      end
      TX_START: begin
        if (txTick) begin
          s_nxt.txState = TX_DATA;
          s_nxt.txd = s_r.txShift[0];
          s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
          s_nxt.txBit = '0;
        end
      end
      TX_DATA: begin
        if (txTick) begin
          if (s_r.txBit == LAST_BIT) begin
            s_nxt.txState = TX_STOP;
            s_nxt.txd = IDLE_LEVEL;
            s_nxt.stopLeft = s_r.cfg.stopTwo;
          end else begin
            s_nxt.txBit = s_r.txBit + BIT_W'(1);
            s_nxt.txd = s_r.txShift[0];
            s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
          end
        end
      end
      TX_STOP: begin
        if (txTick) begin
          if (s_r.stopLeft) begin
            s_nxt.stopLeft = 1'b0;
          end else begin
            s_nxt.txState = TX_IDLE;
          end
        end
      end
    endcase
    s_nxt.txBusy = (s_nxt.txState != TX_IDLE);

    // receiver, sampled mid-bit from the start edge
    s_nxt.rxCnt = rxTick ? bitReload(s_r.cfg.divisor)
                         : s_r.rxCnt - DIV_W'(1);
    if (!rxAllow) begin
      s_nxt.rxState = RX_IDLE;
    end else begin
      unique case (s_r.rxState)
        RX_IDLE: begin
          if (rxd == START_LEVEL) begin
            s_nxt.rxState = RX_START;
            s_nxt.rxCnt = {1'b0, s_r.cfg.divisor[DIV_W-1:1]};
          end
        end
        RX_START: begin
          // a glitch shorter than half a bit is not a start
          if (rxTick) begin
            s_nxt.rxState = (rxd == START_LEVEL) ? RX_DATA : RX_IDLE;
            s_nxt.rxBit = '0;
          end
        end
        RX_DATA: begin
          if (rxTick) begin
            s_nxt.rxShift = {rxd, s_r.rxShift[7:1]};
            if (s_r.rxBit == LAST_BIT) begin
              s_nxt.rxState = RX_STOP;
            end else begin
              s_nxt.rxBit = s_r.rxBit + BIT_W'(1);
            end
          end
        end
        RX_STOP: begin
          // only the first stop bit is checked
          if (rxTick) begin
            s_nxt.rxState = RX_IDLE;
            if (rxd == IDLE_LEVEL) begin
              s_nxt.rxData = s_r.rxShift;
              s_nxt.rxValid = 1'b1;
            end else begin
              s_nxt.rxFrameErr = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign cfgOut = s_r.cfg;
  assign txd = s_r.txd;
  assign rtsOut = s_r.rts;
  assign ctsState = s_r.ctsS;
  assign cdState = s_r.cdS;
  assign rxData = s_r.rxData;
  assign rxValid = s_r.rxValid;
  assign rxFrameErr = s_r.rxFrameErr;
  assign txBusy = s_r.txBusy;

endmodule

// >>> serial_flow_pkg.sv
package serial_flow_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FIRST_PORT_BAUD = 1200;
  localparam int unsigned FRONT_PORT_BAUD = 9600;
  localparam int unsigned PORT_COUNT = 8;
  localparam int unsigned FIRST_PORT_INDEX = 0;
  localparam int unsigned FRONT_PORT_INDEX = 3;

  localparam int unsigned DIV_W = 16;
  localparam int unsigned DELAY_W = 16;
  localparam int unsigned FILL_W = 8;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned BIT_W = 3;

  // divisor = clock cycles per bit
  localparam logic [DIV_W-1:0] FIRST_PORT_DIV =
    DIV_W'(CLK_HZ / FIRST_PORT_BAUD);
  localparam logic [DIV_W-1:0] FRONT_PORT_DIV =
    DIV_W'(CLK_HZ / FRONT_PORT_BAUD);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(DATA_BITS - 1);

  localparam logic START_LEVEL = 1'b0;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic RESET_STOP_TWO = 1'b0;

  typedef enum logic [2:0] {
    FCM_NONE = 3'h0,
    FCM_MANUAL = 3'h1,
    FCM_AUTO_CTS = 3'h2,
    FCM_AUTO_RTS = 3'h3,
    FCM_FULL_AUTO = 3'h4,
    FCM_DYNAMIC = 3'h5,
    FCM_ENHANCED = 3'h6
  } fc_mode_t;

  localparam fc_mode_t RESET_MODE = FCM_NONE;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_START = 2'h1,
    TX_DATA = 2'h3,
    TX_STOP = 2'h2
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_DATA = 2'h3,
    RX_STOP = 2'h2
  } rx_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] divisor;
    fc_mode_t mode;
    logic stopTwo;
  } port_cfg_t;

endpackage

// >>> two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int unsigned WIDTH = 8
) (
  input logic ref_clk,
  input logic nrst,
  input logic [WIDTH-1:0] inData,
  input logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input logic outReady
);

  if (WIDTH < 1) begin : g_chk
    $error("two_entry_buffer: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
    logic notFull;
    logic notEmpty;
  } buf_state_t;

  localparam buf_state_t RESET_STATE = '{
    slot: '0, wrPtr: 1'b0, rdPtr: 1'b0, count: 2'h0,
    notFull: 1'b1, notEmpty: 1'b0};

  buf_state_t s_r;
  buf_state_t s_nxt;
  logic push;
  logic pop;

  assign push = inValid & s_r.notFull;
  assign pop = outReady & s_r.notEmpty;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.slot[s_r.wrPtr] = inData;
      s_nxt.wrPtr = ~s_r.wrPtr;
    end
    if (pop) begin
      s_nxt.rdPtr = ~s_r.rdPtr;
    end
    // simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      s_nxt.count = s_r.count + 2'h1;
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - 2'h1;
    end
    s_nxt.notFull = (s_nxt.count != 2'h2);
    s_nxt.notEmpty = (s_nxt.count != 2'h0);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign inReady = s_r.notFull;
  assign outValid = s_r.notEmpty;
  assign outData = s_r.slot[s_r.rdPtr];

endmodule

// >>> flow_chk.sv
`timescale 1ns/1ps
module flow_chk
  import serial_flow_pkg::*;
(
  input logic ref_clk,
  input logic nrst,
  input logic cfgWrite,
  input serial_flow_pkg::port_cfg_t cfgOut,
  input logic txBusy,
  input logic rtsCmdValid,
  input logic rtsCmdOn,
  input logic [serial_flow_pkg::FILL_W-1:0] rxFill,
  input logic [serial_flow_pkg::FILL_W-1:0] rxLowMark,
  input logic [serial_flow_pkg::FILL_W-1:0] rxHighMark,
  input logic ctsIn,
  input logic cdIn,
  input logic txd,
  input logic rtsOut,
  input logic ctsState,
  input logic cdState,
  input logic rxValid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  fc_mode_t m;
  assign m = cfgOut.mode;
  property p_none; m == FCM_NONE && $past(m) == FCM_NONE
    |-> ctsState && cdState; endproperty
  a_none: assert property (p_none) else $error("lines not forced");
  property p_autoRts; $fell(txd) && !$past(txBusy) && m inside
    {FCM_NONE, FCM_AUTO_RTS, FCM_FULL_AUTO, FCM_ENHANCED}
    |-> $past(rtsOut); endproperty
  a_autoRts: assert property (p_autoRts) else $error("start w/o rts");
  property p_toMan; rtsCmdValid && !cfgWrite && m == FCM_NONE
    |=> cfgOut.mode == FCM_MANUAL; endproperty
  a_toMan: assert property (p_toMan) else $error("no manual switch");
  property p_manRts; rtsCmdValid && !cfgWrite && m == FCM_MANUAL
    |=> rtsOut == $past(rtsCmdOn); endproperty
  a_manRts: assert property (p_manRts) else $error("rts not program");
  property p_manLines; m == FCM_MANUAL && $past(m) == FCM_MANUAL
    |-> ctsState == $past(ctsIn) && cdState == $past(cdIn); endproperty
  a_manLines: assert property (p_manLines) else $error("pins not shown");
  property p_ctsGate; $fell(txd) && !$past(txBusy) && m inside
    {FCM_AUTO_CTS, FCM_FULL_AUTO, FCM_DYNAMIC, FCM_ENHANCED}
    |-> $past(ctsIn); endproperty
  a_ctsGate: assert property (p_ctsGate) else $error("sent w/o cts");
  property p_cd2; m == FCM_AUTO_CTS && $past(m) == FCM_AUTO_CTS
    |-> cdState; endproperty
  a_cd2: assert property (p_cd2) else $error("cd not forced");
  property p_cdGate; m == FCM_FULL_AUTO && !cdIn && !$past(cdIn)
    && !$past(cdIn, 2) |-> !rxValid; endproperty
  a_cdGate: assert property (p_cdGate) else $error("rx w/o cd");
  property p_fillHi; m == FCM_DYNAMIC && !cfgWrite && rxFill > rxHighMark
    |=> !rtsOut; endproperty
  a_fillHi: assert property (p_fillHi) else $error("rts above high");
  property p_fillLo; m == FCM_DYNAMIC && !cfgWrite && rxFill < rxLowMark
    |=> rtsOut; endproperty
  a_fillLo: assert property (p_fillLo) else $error("rts below low");
  property p_hold; txBusy && m inside {FCM_AUTO_RTS, FCM_FULL_AUTO}
    |-> rtsOut; endproperty
  a_hold: assert property (p_hold) else $error("rts dropped early");
  property p_start; $rose(txBusy) |-> !txd; endproperty
  a_start: assert property (p_start) else $error("no start bit");
endmodule
bind serial_port_flow_control flow_chk u_chk (.*);

// >>> modem_model.sv
`timescale 1ns/1ps
module modem_model (
  input wire logic ref_clk,
  input wire logic rtsOut,
  input wire logic ctsAllow,
  input wire logic cdOn,
  input wire logic [15:0] divisor,
  input wire logic sendReq,
  input wire logic [7:0] sendByte,
  input wire logic badStop,
  output logic ctsIn,
  output logic cdIn,
  output logic rxd
);
  logic [9:0] frame;
  logic [2:0] lag;
  initial begin
    ctsIn = 1'b0;
    cdIn = 1'b0;
    rxd = 1'b1;
    lag = 3'h0;
  end
  // cts answers rts a few cycles late and never without it
  always @(posedge ref_clk) begin
    lag <= rtsOut ? lag + 3'(lag != 3'h7) : 3'h0;
    ctsIn <= ctsAllow && rtsOut && lag >= 3'h4;
    cdIn <= cdOn;
  end
  always @(posedge ref_clk) begin
    if (sendReq) begin
      // a low stop bit provokes a framing error
      frame = {~badStop, sendByte, 1'b0};
      for (int i = 0; i < 10; i++) begin
        rxd <= frame[i];
        repeat (divisor) @(posedge ref_clk);
      end
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import serial_flow_pkg::*;
  localparam logic [15:0] DIV = 16'h0008;
  logic ref_clk, nrst, cfgWrite, txValid, rtsCmdValid, rtsCmdOn, sendReq;
  logic txReady, txBusy, ctsIn, cdIn, rxd, txd, rtsOut, ctsAllow, cdOn, g;
  logic ctsState, cdState, rxValid, rxFrameErr, badStop;
  logic [7:0] txData, rxFill, rxLowMark, rxHighMark, rxData, sendByte, b;
  logic [7:0] q [3];
  logic [15:0] rtsOffDelay;
  port_cfg_t cfgIn, cfgOut, cfgOut2;
  int fail_count, num_checks;
  serial_port_flow_control #(.PORT_INDEX(FIRST_PORT_INDEX)) DUT (.*);
  serial_port_flow_control #(.PORT_INDEX(FRONT_PORT_INDEX)) DUT2 (.*,
    .cfgOut(cfgOut2), .txReady(), .txBusy(), .txd(), .rtsOut(),
    .ctsState(), .cdState(), .rxData(), .rxValid(), .rxFrameErr());
  modem_model MDM (.*, .divisor(cfgOut.divisor));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic waitLvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (s !== v) begin
      chk("wait", v, s);
      give_verdict();
    end
  endtask
  task automatic setMode(fc_mode_t md, logic st = 1'b0);
    cfgIn <= '{DIV, md, st};
    cfgWrite <= 1'b1;
    @(posedge ref_clk);
    cfgWrite <= 1'b0;
    @(posedge ref_clk);
    #1 chk("cfgOut", {DIV, md, st}, cfgOut);
  endtask
  task automatic rtsCmd(logic v);
    rtsCmdOn <= v;
    rtsCmdValid <= 1'b1;
    @(posedge ref_clk);
    rtsCmdValid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic push(logic [7:0] d);
    txData <= d;
    txValid <= 1'b1;
    @(posedge ref_clk);
    txValid <= 1'b0;
  endtask
  // stops at mid stop bit so a following start edge is not missed
  task automatic getFrame(logic [7:0] d);
    logic [9:0] f;
    waitLvl(txd, 1'b0);
    repeat (DIV / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      #1 f[i] = txd;
      if (i < 9) repeat (DIV) @(posedge ref_clk);
    end
    chk("frame", {1'b1, d, 1'b0}, f);
  endtask
  task automatic rxChk(logic [7:0] d, logic ok);
    logic got;
    logic fe;
    got = 1'b0;
    fe = 1'b0;
    sendByte <= d;
    sendReq <= 1'b1;
    @(posedge ref_clk);
    sendReq <= 1'b0;
    for (int n = 0; n < 12 * DIV; n++) begin
      @(posedge ref_clk);
      #1 if (rxValid === 1'b1) begin
        got = 1'b1;
        chk("rxData", d, rxData);
      end
      if (rxFrameErr === 1'b1) fe = 1'b1;
    end
    chk("rxValid", ok, got);
    chk("rxFrameErr", badStop, fe);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {nrst, cfgWrite, txValid, rtsCmdValid, rtsCmdOn, sendReq} = 6'h00;
    badStop = 1'b0;
    {txData, rxFill, sendByte, cfgIn} = '0;
    rxLowMark = 8'h04;
    rxHighMark = 8'h08;
    rtsOffDelay = 16'h0001;
    ctsAllow = 1'b1;
    cdOn = 1'b0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(24764));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    #1 chk("first cfg", {FIRST_PORT_DIV, RESET_MODE, 1'b0}, cfgOut);
    chk("front cfg", {FRONT_PORT_DIV, RESET_MODE, 1'b0}, cfgOut2);
    chk("idle", 3'b110, {txd, txReady, rtsOut});
    $display("reset test done");
    for (int m = 0; m < 7; m++) begin
      setMode(fc_mode_t'(m));
      if (m == 2) rtsCmd(1'b1);
      b = (m == 1) ? 8'h00 : (m == 6) ? 8'hFF : 8'($urandom);
      g = m inside {2, 4, 5, 6};
      ctsAllow <= !g;
      push(b);
      if (g) begin
        repeat (20) @(posedge ref_clk);
        #1 chk("gated txd", 1, txd);
        ctsAllow <= 1'b1;
      end
      getFrame(b);
      if (m inside {0, 3, 4, 6}) begin
        repeat (3 * DIV + 4) @(posedge ref_clk);
        #1 chk("rts off", 0, rtsOut);
      end
      if (m == 2) rtsCmd(1'b0);
      if (m == 0) begin
        rxChk(8'($urandom), 1'b1);
        rtsCmd(1'b1);
        #1 chk("mode", FCM_MANUAL, cfgOut.mode);
        chk("prog rts", 1, rtsOut);
        rtsCmd(1'b0);
      end
      if (m == 1) begin
        badStop <= 1'b1;
        rxChk(8'($urandom), 1'b0);
        badStop <= 1'b0;
      end
      if (m == 4) begin
        rxChk(8'($urandom), 1'b0);
        cdOn <= 1'b1;
        rxChk(8'($urandom), 1'b1);
        cdOn <= 1'b0;
      end
      if (m == 5) begin
        rxFill <= 8'h0C;
        repeat (3) @(posedge ref_clk);
        #1 chk("fill rts", 0, rtsOut);
        rxFill <= 8'h00;
      end
      $display("mode %0d test done", m);
    end
    setMode(FCM_AUTO_RTS);
    rtsCmd(1'b1);
    b = 8'($urandom);
    push(b);
    waitLvl(txd, 1'b0);
    rtsCmd(1'b0);
    #1 chk("rts held", 1, rtsOut);
    getFrame(b);
    repeat (3 * DIV + 4) @(posedge ref_clk);
    #1 chk("rts late off", 0, rtsOut);
    $display("rts hold test done");
    setMode(FCM_MANUAL, 1'b1);
    for (int i = 0; i < 3; i++) q[i] = 8'($urandom);
    for (int i = 0, n = 0; i < 3 && n < 50; n++) begin
      txData <= q[i];
      txValid <= 1'b1;
      @(posedge ref_clk);
      if (txReady === 1'b1) i++;
    end
    txValid <= 1'b0;
    #1 chk("full", 0, txReady);
    for (int i = 0; i < 3; i++) getFrame(q[i]);
    #1 chk("drained", 1, txReady);
    $display("buffer test done");
    give_verdict();
  end
endmodule
